// ==== rtl/drg_ctrl.v ====
// Drive run guard, below-limit action and sleep control with AHB-Lite registers
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "drg_defs.vh"
module drg_ctrl #(
   parameter TICK_CYC = `DRG_TICK10_CYC,
   parameter INIT_CYC = `DRG_INIT_CYC
) (
   input wire i_core_clk,
   input wire i_rst_b,
   input wire i_hsel,
   input wire [11:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output wire o_hreadyout,
   output wire o_hresp,
   input wire i_run_term,
   input wire i_run_cmd,
   input wire [15:0] i_set_freq,
   input wire [15:0] i_run_freq,
   input wire [15:0] i_meas_speed,
   output reg o_drive_en,
   output reg [15:0] o_freq_ref,
   output reg o_stop_reached,
   output wire o_run_protect,
   output wire o_sleeping,
   output wire o_init_done
);
// ----------------------------------------
// State codes
// ----------------------------------------
localparam ST_INIT = 6'b000001;
localparam ST_STOP = 6'b000010;
localparam ST_PROT = 6'b000100;
localparam ST_RUN = 6'b001000;
localparam ST_SLEEP = 6'b010000;
localparam ST_LSTOP = 6'b100000;
// ----------------------------------------
// Registers
// ----------------------------------------
reg [5:0] ctrl;
reg [13:0] stop_time;
reg [15:0] wake_time;
reg [15:0] stop_speed;
reg [15:0] low_limit;
reg [5:0] state;
reg [5:0] next_state;
reg [23:0] tick_cnt;
reg tick;
reg [23:0] init_cnt;
reg term_seen;
reg term_prev;
reg [13:0] stop_cnt;
reg [3:0] sub_cnt;
reg [15:0] wake_cnt;
reg ph_wr;
reg ph_rd;
reg [11:0] ph_addr;
wire det_sel;
wire guard;
wire [1:0] act;
wire term_mode;
wire [15:0] cmp_speed;
wire below_set;
wire below_run;
wire run_req;
wire rise;
wire wake_ok;
wire [13:0] stop_lim;
wire [15:0] wake_lim;
wire init_end;
wire ahb_take;
wire [15:0] stop_clamped;
wire [15:0] wake_clamped;
// ----------------------------------------
// Next values
// ----------------------------------------
reg [5:0] next_ctrl;
reg [13:0] next_stop_time;
reg [15:0] next_wake_time;
reg [15:0] next_stop_speed;
reg [15:0] next_low_limit;
reg [31:0] next_hrdata;
reg [15:0] next_freq_ref;
reg [13:0] next_stop_cnt;
reg next_stop_reached;
function [15:0] clamp16;
   input [15:0] val;
   input [15:0] max;
   begin
      clamp16 = (val > max) ? max : val;
   end
endfunction
assign det_sel = ctrl[`DRG_CTRL_DET_BIT] & ~ctrl[`DRG_CTRL_SVM_BIT];
assign guard = ctrl[`DRG_CTRL_GUARD_BIT];
assign act = ctrl[`DRG_CTRL_ACT_LSB+1:`DRG_CTRL_ACT_LSB];
assign term_mode = ctrl[`DRG_CTRL_TERM_BIT];
assign stop_lim = stop_time;
assign wake_lim = wake_time;
assign cmp_speed = det_sel ? i_meas_speed : o_freq_ref;
assign below_set = i_set_freq < low_limit;
assign below_run = i_run_freq < low_limit;
assign run_req = term_mode ? i_run_term : i_run_cmd;
assign rise = i_run_term & ~term_prev;
assign wake_ok = ~below_set && (wake_cnt >= wake_lim);
assign init_end = (init_cnt == INIT_CYC[23:0]);
assign o_run_protect = state[2];
assign o_sleeping = state[4];
assign o_init_done = ~state[0];
assign o_hreadyout = 1'b1;
assign o_hresp = 1'b0;
assign ahb_take = i_hsel & i_hready & i_htrans[1];
// Clamped as 16 bits, then cut back to the register width on purpose
assign stop_clamped = clamp16({2'b00, i_hwdata[13:0]}, {2'b00, `DRG_STOP_TIME_MAX});
assign wake_clamped = clamp16(i_hwdata[15:0], `DRG_WAKE_TIME_MAX);
// ----------------------------------------
// AHB-Lite slave
// ----------------------------------------
always @(posedge i_core_clk) begin
   if (!i_rst_b) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 12'h000;
      o_hrdata <= 32'h00000000;
   end else begin
      ph_wr <= ahb_take & i_hwrite;
      ph_rd <= ahb_take & ~i_hwrite;
      if (ahb_take) begin
         ph_addr <= i_haddr;
      end
      o_hrdata <= next_hrdata;
   end
end
// ----------------------------------------
// Read mux
// ----------------------------------------
// Fed by the next values, so a read right behind a write sees the new word
always @* begin
   next_hrdata = o_hrdata;
   if (ahb_take & ~i_hwrite) begin
      case (i_haddr)
         `DRG_OFS_CTRL: next_hrdata = {26'h0000000, next_ctrl};
         `DRG_OFS_STOP_TIME: next_hrdata = {18'h00000, next_stop_time};
         `DRG_OFS_WAKE_TIME: next_hrdata = {16'h0000, next_wake_time};
         `DRG_OFS_STOP_SPEED: next_hrdata = {16'h0000, next_stop_speed};
         `DRG_OFS_LOW_LIMIT: next_hrdata = {16'h0000, next_low_limit};
         `DRG_OFS_STATUS: next_hrdata = {24'h000000, o_stop_reached, o_drive_en, state};
         default: next_hrdata = 32'h00000000;
      endcase
   end
end
// ----------------------------------------
// Register write path
// ----------------------------------------
// Writes land at the end of the data phase
always @* begin
   next_ctrl = ctrl;
   next_stop_time = stop_time;
   next_wake_time = wake_time;
   next_stop_speed = stop_speed;
   next_low_limit = low_limit;
   if (ph_wr) begin
      case (ph_addr)
         `DRG_OFS_CTRL: next_ctrl = i_hwdata[5:0];
         `DRG_OFS_STOP_TIME: next_stop_time = stop_clamped[13:0];
         `DRG_OFS_WAKE_TIME: next_wake_time = wake_clamped;
         `DRG_OFS_STOP_SPEED: next_stop_speed = i_hwdata[15:0];
         `DRG_OFS_LOW_LIMIT: next_low_limit = i_hwdata[15:0];
         default: next_ctrl = ctrl;
      endcase
   end
end
always @(posedge i_core_clk) begin
   if (!i_rst_b) begin
      ctrl <= `DRG_CTRL_RST;
      stop_time <= `DRG_STOP_TIME_RST;
      wake_time <= `DRG_WAKE_TIME_RST;
      stop_speed <= `DRG_STOP_SPEED_RST;
      low_limit <= `DRG_LOW_LIMIT_RST;
   end else begin
      ctrl <= next_ctrl;
      stop_time <= next_stop_time;
      wake_time <= next_wake_time;
      stop_speed <= next_stop_speed;
      low_limit <= next_low_limit;
   end
end
// ----------------------------------------
// 10 ms tick and power-up window
// ----------------------------------------
always @(posedge i_core_clk) begin
   if (!i_rst_b) begin
      tick_cnt <= 24'h000000;
      tick <= 1'b0;
      init_cnt <= 24'h000000;
      term_seen <= 1'b0;
      term_prev <= 1'b0;
   end else begin
      // Free running, so a timed span may start anywhere within a tick
      tick <= (tick_cnt == TICK_CYC[23:0] - 24'h000001);
      tick_cnt <= (tick_cnt == TICK_CYC[23:0] - 24'h000001) ? 24'h000000 : tick_cnt + 24'h000001;
      term_prev <= i_run_term;
      if (state[0]) begin
         init_cnt <= init_end ? init_cnt : init_cnt + 24'h000001;
         // Sampled through the whole window, not one instant
         if (term_mode & i_run_term) begin
            term_seen <= 1'b1;
         end
      end
   end
end
// ----------------------------------------
// Stop speed qualification
// ----------------------------------------
always @(posedge i_core_clk) begin
   if (!i_rst_b) begin
      stop_cnt <= 14'h0000;
      o_stop_reached <= 1'b0;
   end else begin
      stop_cnt <= next_stop_cnt;
      o_stop_reached <= next_stop_reached;
   end
end
always @* begin
   next_stop_cnt = stop_cnt;
   next_stop_reached = o_stop_reached;
   if (cmp_speed > stop_speed) begin
      // Any rise above the stop speed restarts the qualification time
      next_stop_cnt = 14'h0000;
      next_stop_reached = 1'b0;
   end else if (stop_cnt >= stop_lim) begin
      next_stop_reached = 1'b1;
   end else if (tick) begin
      next_stop_cnt = stop_cnt + 14'h0001;
   end
end
// ----------------------------------------
// Wake delay, counted in 100 ms steps
// ----------------------------------------
always @(posedge i_core_clk) begin
   if (!i_rst_b) begin
      wake_cnt <= 16'h0000;
      sub_cnt <= 4'h0;
   end else if (!state[4] || below_set) begin
      // Any dip restarts the whole delay
      wake_cnt <= 16'h0000;
      sub_cnt <= 4'h0;
   // Tick phase is free, so the delay may run up to one tick short
   end else if (tick && wake_cnt < wake_lim) begin
      if (sub_cnt == 4'h9) begin
         sub_cnt <= 4'h0;
         wake_cnt <= wake_cnt + 16'h0001;
      end else begin
         sub_cnt <= sub_cnt + 4'h1;
      end
   end
end
// ----------------------------------------
// Run state machine
// ----------------------------------------
always @* begin
   next_state = state;
   case (state)
      ST_INIT: begin
         if (init_end) begin
            if (term_mode & term_seen & guard) begin
               next_state = ST_RUN;
            end else if (term_mode & term_seen) begin
               next_state = ST_PROT;
            end else begin
               next_state = ST_STOP;
            end
         end
      end
      ST_PROT: begin
         // Needs a fresh rising edge after a release
         if (!term_mode || rise) begin
            next_state = ST_STOP;
         end
      end
      ST_STOP: begin
         if (run_req && !(term_mode && !i_run_term)) begin
            next_state = ST_RUN;
         end
      end
      ST_RUN: begin
         if (!run_req) begin
            next_state = ST_STOP;
         end else if (act == `DRG_ACT_SLEEP && (below_set || below_run)) begin
            next_state = ST_SLEEP;
         end else if (act == `DRG_ACT_STOP && below_set) begin
            next_state = ST_LSTOP;
         end
      end
      ST_SLEEP: begin
         if (!run_req) begin
            next_state = ST_STOP;
         end else if (act != `DRG_ACT_SLEEP) begin
            next_state = ST_RUN;
         end else if (wake_ok) begin
            next_state = ST_RUN;
         end
      end
      ST_LSTOP: begin
         if (!run_req) begin
            next_state = ST_STOP;
         end else if (!below_set || act != `DRG_ACT_STOP) begin
            next_state = ST_RUN;
         end
      end
      default: next_state = ST_INIT;
   endcase
end
always @(posedge i_core_clk) begin
   if (!i_rst_b) begin
      state <= ST_INIT;
      o_drive_en <= 1'b0;
      o_freq_ref <= 16'h0000;
   end else begin
      state <= next_state;
      // Output off in sleep lets the motor coast
      o_drive_en <= next_state[3];
      o_freq_ref <= next_freq_ref;
   end
end
// ----------------------------------------
// Frequency reference
// ----------------------------------------
// Zero whenever the drive is off, so stop detection in mode 0 sees rest
always @* begin
   next_freq_ref = 16'h0000;
   if (next_state[3]) begin
      if (below_set && act == `DRG_ACT_LIMIT) begin
         next_freq_ref = low_limit;
      end else begin
         next_freq_ref = i_set_freq;
      end
   end
end
endmodule // drg_ctrl
`default_nettype wire

// ==== rtl/drg_defs.vh ====
// Constants for the drive run guard and sleep control block
// Function
// - Detection mode 0 compares the commanded speed with the stop speed, the only mode for space vector modulation.
// - Detection mode 1 uses the measured speed to judge the stop speed.
// - The stop speed detection time is held from 0.00 to 100.00 s, default 0.50 s, to qualify stop.
// - With terminal run control the run terminal is sampled during power-up.
// - Guard 0 ignores a run terminal active at power-up, stays stopped and enters run protection.
// - Guard 1 starts running after initialisation if the run terminal was active at power-up.
// - Below the lower limit the selector picks 0 run at limit, 1 stop, 2 sleep; default 0.
// - In sleep handling a set frequency below the limit removes drive output and coasts.
// - The running frequency falling below the limit with sleep selected enters sleep.
// - Sleep ends only after the set frequency stays above the limit for the wake delay; a selector change or a dropped run command also ends it at once.
// - The wake delay is held with a default of 0.0 s.
// - The wake delay spans 0.0 to 3600.0 s and acts only with selector 2.
`ifndef DRG_DEFS_VH
`define DRG_DEFS_VH
// ----------------------------------------
// AHB register offsets
// ----------------------------------------
`define DRG_OFS_CTRL 12'h000
`define DRG_OFS_STOP_TIME 12'h004
`define DRG_OFS_WAKE_TIME 12'h008
`define DRG_OFS_STOP_SPEED 12'h00C
`define DRG_OFS_LOW_LIMIT 12'h010
`define DRG_OFS_STATUS 12'h014
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DRG_CTRL_DET_BIT 0
`define DRG_CTRL_GUARD_BIT 1
`define DRG_CTRL_ACT_LSB 2
`define DRG_CTRL_SVM_BIT 4
`define DRG_CTRL_TERM_BIT 5
`define DRG_CTRL_RST 6'h20
`define DRG_ACT_LIMIT 2'h0
`define DRG_ACT_STOP 2'h1
`define DRG_ACT_SLEEP 2'h2
`define DRG_STOP_TIME_RST 14'h0032
`define DRG_STOP_TIME_MAX 14'h2710
`define DRG_WAKE_TIME_RST 16'h0000
`define DRG_WAKE_TIME_MAX 16'h8CA0
`define DRG_STOP_SPEED_RST 16'h0032
`define DRG_LOW_LIMIT_RST 16'h0000
// ----------------------------------------
// Timing: stop time in 10 ms, wake time in 100 ms
// ----------------------------------------
`define DRG_CLK_HZ 125000000
`define DRG_TICK10_MS 10
`define DRG_TICK10_CYC (`DRG_CLK_HZ / 1000 * `DRG_TICK10_MS)
`define DRG_INIT_US 100
`define DRG_INIT_CYC (`DRG_CLK_HZ / 1000000 * `DRG_INIT_US)
`endif

// ==== test/drg_src_model.sv ====
// Model of the run terminal and frequency setpoint source
`timescale 1ns/1ps
`default_nettype none
module drg_src_model (
   input wire logic i_core_clk,
   input wire logic i_term_req,
   input wire logic [15:0] i_set_req,
   input wire logic [15:0] i_meas_req,
   output logic o_run_term,
   output logic [15:0] o_set_freq,
   output logic [15:0] o_run_freq,
   output logic [15:0] o_meas_speed
);
   // No ramp: the running frequency tracks the setpoint at once
   always @(posedge i_core_clk) begin
      o_run_term <= i_term_req;
      o_set_freq <= i_set_req;
      o_run_freq <= i_set_req;
      o_meas_speed <= i_meas_req;
   end
endmodule // drg_src_model
`default_nettype wire

// ==== test/drg_ctrl_asserts.sv ====
// Port checker for the run guard and sleep control block
`timescale 1ns/1ps
`default_nettype none
module drg_ctrl_asserts #(
   parameter INIT_CYC = 8
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic o_drive_en,
   input wire logic [15:0] o_freq_ref,
   input wire logic o_run_protect,
   input wire logic o_sleeping,
   input wire logic o_init_done
);
   logic [15:0] cnt;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   // Saturating count of cycles since reset release
   always @(posedge i_core_clk) begin
      if (!i_rst_b) cnt <= 16'h0000;
      else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
   end
   resp_okay_a: assert property (o_hresp == 1'b0) else $error("hresp not okay");
   zero_wait_a: assert property (o_hreadyout) else $error("hreadyout low");
   init_min_a: assert property ($rose(o_init_done) |-> cnt >= INIT_CYC - 1)
      else $error("init ended early");
   init_max_a: assert property (cnt > INIT_CYC + 2 |-> o_init_done)
      else $error("init never ended");
   init_idle_a: assert property (!o_init_done |-> !o_drive_en)
      else $error("drive during init");
   prot_idle_a: assert property (o_run_protect |=> !o_drive_en)
      else $error("drive left protection at once");
   sleep_idle_a: assert property (o_sleeping |-> !o_drive_en)
      else $error("drive while sleeping");
   ref_zero_a: assert property (!o_drive_en |-> o_freq_ref == 16'h0000)
      else $error("reference while stopped");
   wake_hold_a: assert property ($rose(o_sleeping) |=> o_sleeping[*8])
      else $error("sleep ended too soon");
   cover property ($fell(o_run_protect));
   cover property ($rose(o_sleeping));
   cover property ($fell(o_sleeping));
endmodule // drg_ctrl_asserts
bind drg_ctrl drg_ctrl_asserts #(.INIT_CYC(INIT_CYC)) u_chk (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .o_drive_en(o_drive_en), .o_freq_ref(o_freq_ref),
   .o_run_protect(o_run_protect), .o_sleeping(o_sleeping), .o_init_done(o_init_done));
`default_nettype wire

// ==== test/drive_run_guard_sleep_control_tb.sv ====
// Testbench of the run guard and sleep control block
`timescale 1ns/1ps
`default_nettype none
`include "drg_defs.vh"
module drive_run_guard_sleep_control_tb;
   logic clk, rst_b, hsel, hwrite, term_req, run_term, drive_en, rdy, resp;
   logic stop_hit, prot, sleeping, init_done;
   logic [1:0] htrans;
   logic [11:0] haddr;
   logic [31:0] hwdata, hrdata, r;
   logic [15:0] set_req, meas_req, set_f, run_f, meas_s, fref, f;
   int miscompares = 0;
   int n_compared = 0;
   localparam logic [15:0] LOW_LIM = 16'h03E8;
   drg_ctrl #(.TICK_CYC(10), .INIT_CYC(8)) uut (.i_core_clk(clk), .i_rst_b(rst_b),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
      .o_hreadyout(rdy), .o_hresp(resp), .i_run_term(run_term), .i_run_cmd(1'b0),
      .i_set_freq(set_f), .i_run_freq(run_f), .i_meas_speed(meas_s),
      .o_drive_en(drive_en), .o_freq_ref(fref), .o_stop_reached(stop_hit),
      .o_run_protect(prot), .o_sleeping(sleeping), .o_init_done(init_done));
   drg_src_model u_src (.i_core_clk(clk), .i_term_req(term_req), .i_set_req(set_req),
      .i_meas_req(meas_req), .o_run_term(run_term), .o_set_freq(set_f),
      .o_run_freq(run_f), .o_meas_speed(meas_s));
   task complete_run;
      if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Expected reference with the run-at-limit action selected
   function automatic logic [15:0] exp_ref(input logic [15:0] s);
      return (s < LOW_LIM) ? LOW_LIM : s;
   endfunction
   // Single AHB-Lite transfer; waits on hready in both phases
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      r = hrdata;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk("hrdata", e, r);
   endtask
   task wait_drive(input logic v, input int n);
      int k;
      k = 0;
      while (drive_en !== v && k < n) begin
         @(posedge clk);
         k++;
      end
      chk("drive_en", {31'h0, v}, {31'h0, drive_en});
   endtask
   task hold(input logic [15:0] s, input int n);
      set_req <= s;
      repeat (n) @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200000;
      miscompares++;
      complete_run;
   end
   initial begin
      rst_b = 0; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0;
      term_req = 1; set_req = 0; meas_req = 0;
      void'($urandom(66281));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd(`DRG_OFS_CTRL, 32'h20);
      rd(`DRG_OFS_STOP_TIME, 32'h32);
      rd(`DRG_OFS_WAKE_TIME, 32'h0);
      rd(12'h020, 32'h0);
      repeat (20) @(posedge clk);
      chk("run_protect", 32'h1, {31'h0, prot});
      chk("drive_en", 32'h0, {31'h0, drive_en});
      // Terminal must drop and rise again to leave protection
      term_req <= 1'b0;
      repeat (3) @(posedge clk);
      term_req <= 1'b1;
      wait_drive(1'b1, 10);
      wr(`DRG_OFS_LOW_LIMIT, {16'h0000, LOW_LIM});
      // Two corners at the limit, then random setpoints on both sides
      for (int i = 0; i < 6; i++) begin
         f = (i == 0) ? 16'h03E7 : (i == 1) ? 16'h03E8 : 16'($urandom % 5000);
         hold(f, 5);
         chk("freq_ref", {16'h0000, exp_ref(f)}, {16'h0000, fref});
      end
      hold(16'h01F4, 5);
      chk("freq_ref", {16'h0000, exp_ref(16'h01F4)}, {16'h0000, fref});
      wr(`DRG_OFS_CTRL, 32'h24);
      wait_drive(1'b0, 10);
      hold(16'd2000, 1);
      wait_drive(1'b1, 10);
      // Stopped with the measured speed high: only mode 1 sees it
      hold(16'd0, 1);
      meas_req <= 16'd1000;
      wr(`DRG_OFS_STOP_TIME, 32'h1);
      repeat (30) @(posedge clk);
      chk("stop_reached", 32'h1, {31'h0, stop_hit});
      wr(`DRG_OFS_CTRL, 32'h25);
      repeat (30) @(posedge clk);
      chk("stop_reached", 32'h0, {31'h0, stop_hit});
      wr(`DRG_OFS_CTRL, 32'h35);
      repeat (30) @(posedge clk);
      chk("stop_reached", 32'h1, {31'h0, stop_hit});
      wr(`DRG_OFS_CTRL, 32'h28);
      wr(`DRG_OFS_WAKE_TIME, 32'h1);
      hold(16'd2000, 1);
      wait_drive(1'b1, 150);
      hold(16'd500, 5);
      chk("sleeping", 32'h1, {31'h0, sleeping});
      chk("drive_en", 32'h0, {31'h0, drive_en});
      hold(16'd2000, 50);
      hold(16'd500, 2);
      hold(16'd2000, 80);
      chk("sleeping", 32'h1, {31'h0, sleeping});
      wait_drive(1'b1, 50);
      wr(`DRG_OFS_WAKE_TIME, 32'hFFFF);
      rd(`DRG_OFS_WAKE_TIME, 32'h8CA0);
      wr(`DRG_OFS_STOP_TIME, 32'hFFFF);
      rd(`DRG_OFS_STOP_TIME, 32'h2710);
      // Second power-up, guard set early in the window with the terminal held
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      wr(`DRG_OFS_CTRL, 32'h00000022);
      repeat (20) @(posedge clk);
      chk("run_protect", 32'h0, {31'h0, prot});
      chk("drive_en", 32'h1, {31'h0, drive_en});
      complete_run;
   end
endmodule // drive_run_guard_sleep_control_tb
`default_nettype wire
